// ### rtl/ocd_cond_eval.sv
// condition evaluator: tells whether a three-bit condition field holds
// assumes flags ordered sign, zero, parity, carry from the same clock domain
`default_nettype none
module ocd_cond_eval
	import ocd_pkg::*;
(
	// condition and flags
	input  wire logic [2:0] i_cond,
	input  wire logic [3:0] i_flags,
	// result
	output logic            o_true
);
	always_comb
	begin
		case (i_cond)
			COND_NZ: o_true = ~i_flags[FLAG_Z];
			COND_Z:  o_true = i_flags[FLAG_Z];
			COND_NC: o_true = ~i_flags[FLAG_C];
			COND_C:  o_true = i_flags[FLAG_C];
			COND_PO: o_true = ~i_flags[FLAG_P];
			COND_PE: o_true = i_flags[FLAG_P];
			COND_P:  o_true = ~i_flags[FLAG_S];
			COND_M:  o_true = i_flags[FLAG_S];
			default: o_true = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### rtl/ocd_decoder.sv
// opcode decoder with per-opcode clock-cycle table
// assumes i_opcode, i_valid and i_flags come from fetch logic on i_clk, so no synchroniser
`default_nettype none
// How it works
// - field codes 000..101 pick B,C,D,E,H,L; 110 memory; 111 accumulator
// - conditional call 11 or 17 cycles, conditional return 5 or 11
// - opcode EB swaps DE with HL in 4 cycles
// - opcode F9 copies HL into stack pointer in 5 cycles
// - 11pp0101 pushes a pair or accumulator-flags word in 11 cycles
// - 11pp0001 pops a pair or accumulator-flags word in 10 cycles
// - 00pp1001 adds BC, DE, HL or SP into HL in 10 cycles
// - subtract and subtract-with-borrow: 4 cycles register, 7 memory
// - immediate subtract and subtract-with-borrow take 7 cycles
// - AND, XOR, OR register with accumulator in 4 cycles
// - logical ops with memory source take 7 cycles
// - compare register 4 cycles, memory 7 cycles
// - immediate AND, XOR, OR take 7 cycles
// - immediate compare takes 7 cycles
// - rotate left and rotate left through carry take 4 cycles
// - rotate right and rotate right through carry take 4 cycles
// - condition field shared by conditional return, jump and call
module ocd_decoder
	import ocd_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// opcode from fetch
	input  wire logic       i_valid,
	input  wire logic [7:0] i_opcode,
	input  wire logic [3:0] i_flags,
	// decoded result, one cycle after the opcode is taken
	output logic            o_valid,
	output ocd_op_t         o_op,
	output logic [4:0]      o_cycles,
	output logic [2:0]      o_dest_field,
	output logic [2:0]      o_source_field,
	output logic [1:0]      o_pair,
	output logic            o_memory_operand,
	output logic            o_immediate,
	output logic            o_cond_taken,
	output logic            o_illegal
);
	logic [2:0] dst;
	logic [2:0] src;
	logic [1:0] pair;
	logic       cond_ok;
	ocd_op_t    op_next;
	logic [4:0] cyc_next;
	logic       mem_next;
	logic       imm_next;
	logic       taken_next;
	logic       known_next;

	assign dst  = i_opcode[5:3];
	assign src  = i_opcode[2:0];
	assign pair = i_opcode[5:4];

	// one condition field for returns, jumps and calls
	ocd_cond_eval u_cond (
		.i_cond  (dst),
		.i_flags (i_flags),
		.o_true  (cond_ok)
	);

	always_comb
	begin
		op_next    = OPC_NONE;
		cyc_next   = CYC_4;
		mem_next   = 1'b0;
		imm_next   = 1'b0;
		taken_next = 1'b0;
		known_next = 1'b1;
		if (i_opcode == OP_SWAP_DE_HL)
		begin
			op_next  = OPC_SWAP;
			cyc_next = CYC_4;
		end
		else if (i_opcode == OP_LOAD_SP_HL)
		begin
			op_next  = OPC_LDSP;
			cyc_next = CYC_5;
		end
		else if (i_opcode == OP_JUMP)
		begin
			op_next    = OPC_JUMP;
			cyc_next   = CYC_10;
			taken_next = 1'b1;
		end
		else if (i_opcode == OP_CALL)
		begin
			op_next    = OPC_CALL;
			cyc_next   = CYC_17;
			taken_next = 1'b1;
		end
		else if (i_opcode == OP_RETURN)
		begin
			op_next    = OPC_RETURN;
			cyc_next   = CYC_10;
			taken_next = 1'b1;
		end
		else if (i_opcode == OP_PORT_IN || i_opcode == OP_PORT_OUT)
		begin
			op_next  = (i_opcode == OP_PORT_IN) ? OPC_PORT_IN : OPC_PORT_OUT;
			cyc_next = CYC_10;
			imm_next = 1'b1;
		end
		else if (i_opcode == OP_INT_ENABLE || i_opcode == OP_INT_DISABLE)
		begin
			op_next  = (i_opcode == OP_INT_ENABLE) ? OPC_INT_EN : OPC_INT_DIS;
			cyc_next = CYC_4;
		end
		else if (i_opcode == OP_NOP)
		begin
			op_next  = OPC_NOP;
			cyc_next = CYC_4;
		end
		else if (i_opcode == OP_HALT)
		begin
			op_next  = OPC_HALT;
			cyc_next = CYC_7;
		end
		else if (i_opcode == OP_ROT_LC || i_opcode == OP_ROT_LT)
		begin
			op_next  = (i_opcode == OP_ROT_LC) ? OPC_ROT_LC : OPC_ROT_LT;
			cyc_next = CYC_4;
		end
		else if (i_opcode == OP_ROT_RC || i_opcode == OP_ROT_RT)
		begin
			op_next  = (i_opcode == OP_ROT_RC) ? OPC_ROT_RC : OPC_ROT_RT;
			cyc_next = CYC_4;
		end
		else if (i_opcode == OP_SUB_IMM || i_opcode == OP_SBB_IMM)
		begin
			op_next  = (i_opcode == OP_SUB_IMM) ? OPC_SUB : OPC_SBB;
			cyc_next = CYC_7;
			imm_next = 1'b1;
		end
		else if (i_opcode == OP_AND_IMM || i_opcode == OP_XOR_IMM || i_opcode == OP_OR_IMM)
		begin
			op_next  = (i_opcode == OP_AND_IMM) ? OPC_AND :
				(i_opcode == OP_XOR_IMM) ? OPC_XOR : OPC_OR;
			cyc_next = CYC_7;
			imm_next = 1'b1;
		end
		else if (i_opcode == OP_CMP_IMM)
		begin
			op_next  = OPC_CMP;
			cyc_next = CYC_7;
			imm_next = 1'b1;
		end
		else if (i_opcode[7:6] == 2'h2 && i_opcode[5:4] != 2'h0)
		begin
			// accumulator group from 10010sss upward; memory source costs 3 extra cycles
			mem_next = (src == REG_MEM);
			cyc_next = mem_next ? CYC_7 : CYC_4;
			case (i_opcode[5:3])
				3'h2:    op_next = OPC_SUB;
				3'h3:    op_next = OPC_SBB;
				3'h4:    op_next = OPC_AND;
				3'h5:    op_next = OPC_XOR;
				3'h6:    op_next = OPC_OR;
				3'h7:    op_next = OPC_CMP;
				default: op_next = OPC_NONE;
			endcase
		end
		else if (i_opcode[7:6] == 2'h3 && i_opcode[3:0] == 4'h5)
		begin
			op_next  = OPC_PUSH;
			cyc_next = CYC_11;
		end
		else if (i_opcode[7:6] == 2'h3 && i_opcode[3:0] == 4'h1)
		begin
			op_next  = OPC_POP;
			cyc_next = CYC_10;
		end
		else if (i_opcode[7:6] == 2'h0 && i_opcode[3:0] == 4'h9)
		begin
			op_next  = OPC_DADD;
			cyc_next = CYC_10;
		end
		else if (i_opcode[7:6] == 2'h3 && src == 3'h0)
		begin
			op_next    = OPC_RETURN;
			taken_next = cond_ok;
			cyc_next   = cond_ok ? CYC_11 : CYC_5;
		end
		else if (i_opcode[7:6] == 2'h3 && src == 3'h2)
		begin
			op_next    = OPC_JUMP;
			taken_next = cond_ok;
			cyc_next   = CYC_10;
		end
		else if (i_opcode[7:6] == 2'h3 && src == 3'h4)
		begin
			op_next    = OPC_CALL;
			taken_next = cond_ok;
			cyc_next   = cond_ok ? CYC_17 : CYC_11;
		end
		else if (i_opcode[7:6] == 2'h3 && src == 3'h7)
		begin
			op_next    = OPC_RESTART;
			cyc_next   = CYC_11;
			taken_next = 1'b1;
		end
		else
		begin
			// opcodes outside this group are left to the load and move decoder
			known_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_valid   <= 1'b0;
			o_illegal <= 1'b0;
		end
		else
		begin
			o_valid   <= i_valid && known_next;
			o_illegal <= i_valid && !known_next;
		end
	end

	// results hold when no opcode is offered, so downstream may sample late
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_op             <= OPC_NONE;
			o_cycles         <= CYC_4;
			o_dest_field     <= REG_B;
			o_source_field   <= REG_B;
			o_pair           <= PAIR_BC;
			o_memory_operand <= 1'b0;
			o_immediate      <= 1'b0;
			o_cond_taken     <= 1'b0;
		end
		else if (i_valid)
		begin
			o_op             <= op_next;
			o_cycles         <= cyc_next;
			o_dest_field     <= dst;
			o_source_field   <= src;
			o_pair           <= pair;
			o_memory_operand <= mem_next;
			o_immediate      <= imm_next;
			o_cond_taken     <= taken_next;
		end
	end

	property p_cond_call;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[2:0] == 3'h4)
			|=> o_cycles == (o_cond_taken ? CYC_17 : CYC_11)
				&& o_op == OPC_CALL;
	endproperty
	a_cond_call: assert property (p_cond_call) else $error("conditional call count wrong");

	property p_cond_ret;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[2:0] == 3'h0)
			|=> o_cycles == (o_cond_taken ? CYC_11 : CYC_5) && o_op == OPC_RETURN;
	endproperty
	a_cond_ret: assert property (p_cond_ret) else $error("conditional return count wrong");

	property p_swap;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode == OP_SWAP_DE_HL) |=> o_op == OPC_SWAP && o_cycles == CYC_4;
	endproperty
	a_swap: assert property (p_swap) else $error("swap decode wrong");

	property p_ldsp;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode == OP_LOAD_SP_HL) |=> o_op == OPC_LDSP && o_cycles == CYC_5;
	endproperty
	a_ldsp: assert property (p_ldsp) else $error("stack pointer load wrong");

	property p_push;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[3:0] == 4'h5)
			|=> o_op == OPC_PUSH && o_cycles == CYC_11 && o_pair == $past(i_opcode[5:4]);
	endproperty
	a_push: assert property (p_push) else $error("push decode wrong");

	property p_pop;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[3:0] == 4'h1)
			|=> o_op == OPC_POP && o_cycles == CYC_10;
	endproperty
	a_pop: assert property (p_pop) else $error("pop decode wrong");

	property p_dadd;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h0 && i_opcode[3:0] == 4'h9)
			|=> o_op == OPC_DADD && o_cycles == CYC_10;
	endproperty
	a_dadd: assert property (p_dadd) else $error("double add decode wrong");

	property p_alu_mem;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h2 && i_opcode[5:4] != 2'h0)
			|=> o_cycles == (o_memory_operand ? CYC_7 : CYC_4)
				&& o_memory_operand == (o_source_field == REG_MEM);
	endproperty
	a_alu_mem: assert property (p_alu_mem) else $error("register group count wrong");

	property p_imm;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[2:0] == 3'h6 && i_opcode[5:4] != 2'h0)
			|=> o_immediate && o_cycles == CYC_7;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate count wrong");

	property p_rotate;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:5] == 3'h0 && i_opcode[2:0] == 3'h7)
			|=> o_cycles == CYC_4 && o_valid;
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate count wrong");

	property p_jump;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode[7:6] == 2'h3 && i_opcode[2:0] == 3'h2)
			|=> o_op == OPC_JUMP && o_cycles == CYC_10;
	endproperty
	a_jump: assert property (p_jump) else $error("jump decode wrong");

	property p_halt;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_valid && i_opcode == OP_HALT) |=> o_op == OPC_HALT && o_cycles == CYC_7;
	endproperty
	a_halt: assert property (p_halt) else $error("halt decode wrong");
endmodule
`default_nettype wire

// ### rtl/ocd_pkg.sv
// package for the opcode decoder: opcode patterns, field codes, cycle counts
// assumes single-byte opcodes presented by the fetch logic on the processor clock
`default_nettype none
package ocd_pkg;
	// register field codes
	localparam logic [2:0] REG_B   = 3'h0;
	localparam logic [2:0] REG_C   = 3'h1;
	localparam logic [2:0] REG_D   = 3'h2;
	localparam logic [2:0] REG_E   = 3'h3;
	localparam logic [2:0] REG_H   = 3'h4;
	localparam logic [2:0] REG_L   = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A   = 3'h7;
	// pair field codes
	localparam logic [1:0] PAIR_BC = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h1;
	localparam logic [1:0] PAIR_HL = 2'h2;
	localparam logic [1:0] PAIR_SP = 2'h3;
	// condition codes
	localparam logic [2:0] COND_NZ = 3'h0;
	localparam logic [2:0] COND_Z  = 3'h1;
	localparam logic [2:0] COND_NC = 3'h2;
	localparam logic [2:0] COND_C  = 3'h3;
	localparam logic [2:0] COND_PO = 3'h4;
	localparam logic [2:0] COND_PE = 3'h5;
	localparam logic [2:0] COND_P  = 3'h6;
	localparam logic [2:0] COND_M  = 3'h7;
	// fixed opcodes
	localparam logic [7:0] OP_SWAP_DE_HL   = 8'hEB;
	localparam logic [7:0] OP_LOAD_SP_HL   = 8'hF9;
	localparam logic [7:0] OP_SUB_IMM      = 8'hD6;
	localparam logic [7:0] OP_SBB_IMM      = 8'hDE;
	localparam logic [7:0] OP_AND_IMM      = 8'hE6;
	localparam logic [7:0] OP_XOR_IMM      = 8'hEE;
	localparam logic [7:0] OP_OR_IMM       = 8'hF6;
	localparam logic [7:0] OP_CMP_IMM      = 8'hFE;
	localparam logic [7:0] OP_ROT_LC       = 8'h07;
	localparam logic [7:0] OP_ROT_RC       = 8'h0F;
	localparam logic [7:0] OP_ROT_LT       = 8'h17;
	localparam logic [7:0] OP_ROT_RT       = 8'h1F;
	localparam logic [7:0] OP_JUMP         = 8'hC3;
	localparam logic [7:0] OP_CALL         = 8'hCD;
	localparam logic [7:0] OP_RETURN       = 8'hC9;
	localparam logic [7:0] OP_PORT_IN      = 8'hDB;
	localparam logic [7:0] OP_PORT_OUT     = 8'hD3;
	localparam logic [7:0] OP_INT_ENABLE   = 8'hFB;
	localparam logic [7:0] OP_INT_DISABLE  = 8'hF3;
	localparam logic [7:0] OP_NOP          = 8'h00;
	localparam logic [7:0] OP_HALT         = 8'h76;
	// cycle counts
	localparam logic [4:0] CYC_4  = 5'h04;
	localparam logic [4:0] CYC_5  = 5'h05;
	localparam logic [4:0] CYC_7  = 5'h07;
	localparam logic [4:0] CYC_10 = 5'h0A;
	localparam logic [4:0] CYC_11 = 5'h0B;
	localparam logic [4:0] CYC_17 = 5'h11;
	// flag vector positions: sign, zero, parity, carry
	localparam int FLAG_S = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_P = 1;
	localparam int FLAG_C = 0;
	// decoded operation classes
	typedef enum logic [4:0] {
		OPC_NONE     = 5'h00,
		OPC_SWAP     = 5'h01,
		OPC_LDSP     = 5'h02,
		OPC_PUSH     = 5'h03,
		OPC_POP      = 5'h04,
		OPC_DADD     = 5'h05,
		OPC_SUB      = 5'h06,
		OPC_SBB      = 5'h07,
		OPC_AND      = 5'h08,
		OPC_XOR      = 5'h09,
		OPC_OR       = 5'h0A,
		OPC_CMP      = 5'h0B,
		OPC_ROT_LC   = 5'h0C,
		OPC_ROT_RC   = 5'h0D,
		OPC_ROT_LT   = 5'h0E,
		OPC_ROT_RT   = 5'h0F,
		OPC_JUMP     = 5'h10,
		OPC_CALL     = 5'h11,
		OPC_RETURN   = 5'h12,
		OPC_RESTART  = 5'h13,
		OPC_PORT_IN  = 5'h14,
		OPC_PORT_OUT = 5'h15,
		OPC_INT_EN   = 5'h16,
		OPC_INT_DIS  = 5'h17,
		OPC_NOP      = 5'h18,
		OPC_HALT     = 5'h19
	} ocd_op_t;
endpackage
`default_nettype wire

// ### test/ocd_decoder_test.sv
// self-checking bench for the opcode decoder: drives opcodes and checks each decode
// assumes the decoder answers at the rising edge that takes the opcode, read at the next falling edge
`default_nettype none
module ocd_decoder_test
	import ocd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       i_clk;
	logic       i_reset_n;
	logic       i_valid;
	logic [7:0] i_opcode;
	logic [3:0] i_flags;
	logic       o_valid;
	ocd_op_t    o_op;
	logic [4:0] o_cycles;
	logic [2:0] o_dest_field;
	logic [2:0] o_source_field;
	logic [1:0] o_pair;
	logic       o_memory_operand;
	logic       o_immediate;
	logic       o_cond_taken;
	logic       o_illegal;
	int         errors;
	int         n_tests;

	ocd_decoder ocd_decoder_i (
		.i_clk            (i_clk),
		.i_reset_n        (i_reset_n),
		.i_valid          (i_valid),
		.i_opcode         (i_opcode),
		.i_flags          (i_flags),
		.o_valid          (o_valid),
		.o_op             (o_op),
		.o_cycles         (o_cycles),
		.o_dest_field     (o_dest_field),
		.o_source_field   (o_source_field),
		.o_pair           (o_pair),
		.o_memory_operand (o_memory_operand),
		.o_immediate      (o_immediate),
		.o_cond_taken     (o_cond_taken),
		.o_illegal        (o_illegal)
	);

	always #5 i_clk = ~i_clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// called at a falling edge; leaves i_valid high so calls run back to back
	task automatic issue(input logic [7:0] op, input logic [3:0] fl, input ocd_op_t cls,
		input logic [4:0] cyc);
		i_valid = 1'b1;
		i_opcode = op;
		i_flags = fl;
		@(negedge i_clk);
		check({7'h00, o_valid}, 8'h01, "valid");
		check({7'h00, o_illegal}, 8'h00, "illegal");
		check({3'h0, o_op}, {3'h0, cls}, "class");
		check({3'h0, o_cycles}, {3'h0, cyc}, "cycles");
		check({5'h00, o_dest_field}, {5'h00, op[5:3]}, "dest field");
		check({5'h00, o_source_field}, {5'h00, op[2:0]}, "source field");
		check({6'h00, o_pair}, {6'h00, op[5:4]}, "pair");
	endtask

	// reset asserted and released at falling edges; outputs judged away from the rising edge
	task automatic do_reset();
		i_valid = 1'b0;
		i_reset_n = 1'b0;
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		check({7'h00, o_valid}, 8'h00, "valid in reset");
		check({7'h00, o_illegal}, 8'h00, "illegal in reset");
		check({3'h0, o_op}, {3'h0, OPC_NONE}, "class in reset");
		check({3'h0, o_cycles}, {3'h0, CYC_4}, "cycles in reset");
		i_reset_n = 1'b1;
	endtask

	function automatic logic cond_true(input logic [2:0] c, input logic [3:0] fl);
		int idx;
		idx = (c[2:1] == 2'h0) ? FLAG_Z : (c[2:1] == 2'h1) ? FLAG_C :
			(c[2:1] == 2'h2) ? FLAG_P : FLAG_S;
		return fl[idx] == c[0];
	endfunction

	task automatic t_alu();
		ocd_op_t cls [8];
		cls = '{OPC_NONE, OPC_NONE, OPC_SUB, OPC_SBB, OPC_AND, OPC_XOR, OPC_OR, OPC_CMP};
		for (logic [3:0] g = 4'h2; g < 4'h8; g++)
		begin
			for (logic [3:0] s = 4'h0; s < 4'h8; s++)
			begin
				issue({2'h2, g[2:0], s[2:0]}, 4'h0, cls[g], (s == 4'h6) ? CYC_7 : CYC_4);
				check({7'h00, o_memory_operand}, {7'h00, s == 4'h6}, "memory operand");
				check({7'h00, o_immediate}, 8'h00, "immediate");
			end
			issue({2'h3, g[2:0], 3'h6}, 4'h0, cls[g], CYC_7);
			check({7'h00, o_immediate}, 8'h01, "immediate");
		end
	endtask

	task automatic t_cond();
		logic [3:0] fl;
		logic [3:0] pat [4];
		logic       tk;
		for (logic [3:0] c = 4'h0; c < 4'h8; c++)
		begin
			fl = 4'h1 << ((c[2:1] == 2'h0) ? FLAG_Z : (c[2:1] == 2'h1) ? FLAG_C :
				(c[2:1] == 2'h2) ? FLAG_P : FLAG_S);
			pat = '{4'h0, 4'hF, fl, ~fl};
			for (int k = 0; k < 4; k++)
			begin
				tk = cond_true(c[2:0], pat[k]);
				issue({2'h3, c[2:0], 3'h0}, pat[k], OPC_RETURN, tk ? CYC_11 : CYC_5);
				check({7'h00, o_cond_taken}, {7'h00, tk}, "return taken");
				issue({2'h3, c[2:0], 3'h2}, pat[k], OPC_JUMP, CYC_10);
				check({7'h00, o_cond_taken}, {7'h00, tk}, "jump taken");
				issue({2'h3, c[2:0], 3'h4}, pat[k], OPC_CALL, tk ? CYC_17 : CYC_11);
				check({7'h00, o_cond_taken}, {7'h00, tk}, "call taken");
			end
		end
	endtask

	task automatic t_pairs();
		for (logic [2:0] p = 3'h0; p < 3'h4; p++)
		begin
			issue({2'h3, p[1:0], 4'h5}, 4'h0, OPC_PUSH, CYC_11);
			issue({2'h3, p[1:0], 4'h1}, 4'h0, OPC_POP, CYC_10);
			issue({2'h0, p[1:0], 4'h9}, 4'h0, OPC_DADD, CYC_10);
		end
		for (logic [3:0] a = 4'h0; a < 4'h8; a++)
		begin
			issue({2'h3, a[2:0], 3'h7}, 4'h0, OPC_RESTART, CYC_11);
			check({7'h00, o_cond_taken}, 8'h01, "restart taken");
		end
	endtask

	task automatic t_fixed();
		issue(OP_SWAP_DE_HL, 4'h0, OPC_SWAP, CYC_4);
		issue(OP_LOAD_SP_HL, 4'h0, OPC_LDSP, CYC_5);
		issue(OP_ROT_LC, 4'h0, OPC_ROT_LC, CYC_4);
		issue(OP_ROT_LT, 4'h0, OPC_ROT_LT, CYC_4);
		issue(OP_ROT_RC, 4'h0, OPC_ROT_RC, CYC_4);
		issue(OP_ROT_RT, 4'h0, OPC_ROT_RT, CYC_4);
		issue(OP_JUMP, 4'h0, OPC_JUMP, CYC_10);
		check({7'h00, o_cond_taken}, 8'h01, "jump taken");
		issue(OP_CALL, 4'h0, OPC_CALL, CYC_17);
		check({7'h00, o_cond_taken}, 8'h01, "call taken");
		issue(OP_RETURN, 4'h0, OPC_RETURN, CYC_10);
		check({7'h00, o_cond_taken}, 8'h01, "return taken");
		issue(OP_PORT_IN, 4'h0, OPC_PORT_IN, CYC_10);
		check({7'h00, o_immediate}, 8'h01, "port byte");
		issue(OP_PORT_OUT, 4'h0, OPC_PORT_OUT, CYC_10);
		issue(OP_INT_ENABLE, 4'h0, OPC_INT_EN, CYC_4);
		issue(OP_INT_DISABLE, 4'h0, OPC_INT_DIS, CYC_4);
		issue(OP_NOP, 4'h0, OPC_NOP, CYC_4);
		issue(OP_HALT, 4'h0, OPC_HALT, CYC_7);
		// an add opcode lies outside this group and must not pass as recognised
		i_opcode = 8'h80;
		@(negedge i_clk);
		check({7'h00, o_valid}, 8'h00, "add not valid");
		check({7'h00, o_illegal}, 8'h01, "add illegal");
		i_valid = 1'b0;
		@(negedge i_clk);
		check({6'h00, o_valid, o_illegal}, 8'h00, "idle pulse");
	endtask

	initial
	begin
		i_clk = 1'b0;
		i_reset_n = 1'b0;
		i_valid = 1'b0;
		i_opcode = 8'h00;
		i_flags = 4'h0;
		errors = 0;
		n_tests = 0;
		do_reset();
		t_fixed();
		t_alu();
		t_pairs();
		t_cond();
		// second reset in mid-run must clear the decode again
		do_reset();
		issue(OP_CALL, 4'h0, OPC_CALL, CYC_17);
		i_valid = 1'b0;
		@(negedge i_clk);
		summarize();
	end

	// about 210 cycles of traffic; the limit leaves wide margin
	initial
	begin
		#20000;
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
